/* File: osc_ctrl.sv */
// Purpose: oscillator enable, stability and halt-time keep control
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: four 32-bit words, at most the low 4 bits used in each
//
// Summary of operation
// - high keep bit 1 keeps fast oscillator running while halted
// - low keep bit 1 keeps slow oscillator running while halted
// - clock switch completes within bounded cycles after source change
// - rc frequency field: 00 8MHz, 01 12MHz, 10 16MHz, 11 8MHz
// - delivered rc frequency changes only after rc stable goes high
// - rc enable rise or frequency change clears stable until settled
// - rc enable turns rc on, resets to 1
// - drive mode 0 low drive, 1 high drive above 10MHz
// - drive mode freely writable while crystal pins disabled
// - fast crystal enable rise clears stable until settled
// - fast crystal enable turns crystal on, resets to 0
// - slow crystal speed-up bit reads fixed 1
// - slow crystal enable rise clears stable until settled
// - slow crystal enable turns slow crystal on, resets to 0
// - unimplemented upper bits read as zero
// - halt mode from keep bits: sleep, idle0, idle2, idle1
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "osc_defines.svh"
module osc_ctrl
  import osc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_halted,
  input wire logic crystal_pins_enabled,
  output logic internal_fast_rc_osc,
  output logic [1:0] internal_rc_freq_sel,
  output logic fast_crystal_osc,
  output logic crystal_drive_mode,
  output logic slow_crystal_osc,
  output logic slow_crystal_speedup,
  output logic [1:0] halt_mode,
  output logic clock_switch_busy
);
  // ********************************
  // register state
  // ********************************
  logic halt_high_osc_keep;
  logic halt_low_osc_keep;
  logic fast_source_sel;
  logic internal_rc_enable;
  logic fast_crystal_enable;
  logic slow_crystal_enable;
  logic [1:0] freq_req;
  logic [7:0] sys_rd;
  logic [7:0] rc_rd;
  logic [7:0] fxt_rd;
  logic [7:0] sxt_rd;
  logic [2:0] switch_count;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wbyte;
  logic rc_restart;
  logic fxt_restart;
  logic sxt_restart;
  logic osc_run [3];
  logic [2:0] stable_vec;

  function automatic logic [1:0] osc_decode(input logic [3:0] addr);
    if (addr == `OSC_ADDR_SYS)
      osc_decode = 2'h0;
    else if (addr == `OSC_ADDR_RC)
      osc_decode = 2'h1;
    else if (addr == `OSC_ADDR_FXT)
      osc_decode = 2'h2;
    else
      osc_decode = 2'h3;
  endfunction

  // ********************************
  // axi write channel
  // ********************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wbyte = w_strb[0] ? w_data[7:0] : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = 2'b00;

  // ********************************
  // control bits
  // ********************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_high_osc_keep <= 1'b0;
      halt_low_osc_keep <= 1'b0;
      fast_source_sel <= 1'b0;
      internal_rc_enable <= 1'b1;
      freq_req <= 2'b00;
      fast_crystal_enable <= 1'b0;
      crystal_drive_mode <= 1'b0;
      slow_crystal_enable <= 1'b0;
    end
    else if (do_write && w_strb[0])
    begin
      if (osc_decode(aw_addr) == 2'h0)
      begin
        halt_high_osc_keep <= wbyte[`OSC_BIT_KEEP_HIGH];
        halt_low_osc_keep <= wbyte[`OSC_BIT_KEEP_LOW];
        fast_source_sel <= wbyte[`OSC_BIT_FAST_SEL];
      end
      else if (osc_decode(aw_addr) == 2'h1)
      begin
        internal_rc_enable <= wbyte[`OSC_BIT_EN];
        freq_req <= wbyte[3:2];
      end
      else if (osc_decode(aw_addr) == 2'h2)
      begin
        fast_crystal_enable <= wbyte[`OSC_BIT_EN];
        // changes only when pins are off or the crystal is disabled
        if (!crystal_pins_enabled || !fast_crystal_enable)
          crystal_drive_mode <= wbyte[`OSC_BIT_MODE];
      end
      else
        slow_crystal_enable <= wbyte[`OSC_BIT_EN]; // stable and speed-up untouched
    end
  end

  // ********************************
  // settle timers
  // ********************************
  assign rc_restart = do_write && w_strb[0] && osc_decode(aw_addr) == 2'h1 &&
    ((wbyte[`OSC_BIT_EN] && !internal_rc_enable) || wbyte[3:2] != freq_req);
  assign fxt_restart = do_write && w_strb[0] && osc_decode(aw_addr) == 2'h2 &&
    wbyte[`OSC_BIT_EN] && !fast_crystal_enable;
  assign sxt_restart = do_write && w_strb[0] && osc_decode(aw_addr) == 2'h3 &&
    wbyte[`OSC_BIT_EN] && !slow_crystal_enable;

  // oscillator runs while enabled, and while halted only if kept
  assign internal_fast_rc_osc = internal_rc_enable &&
    (!cpu_halted || halt_high_osc_keep);
  assign fast_crystal_osc = fast_crystal_enable &&
    (!cpu_halted || halt_high_osc_keep);
  assign slow_crystal_osc = slow_crystal_enable &&
    (!cpu_halted || halt_low_osc_keep);
  assign slow_crystal_speedup = 1'b1;
  assign halt_mode = {halt_high_osc_keep, halt_low_osc_keep};
  assign osc_run[0] = internal_fast_rc_osc;
  assign osc_run[1] = fast_crystal_osc;
  assign osc_run[2] = slow_crystal_osc;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_settle
      localparam int unsigned CYC = (gi == 0) ? `OSC_RC_STABLE_CYC :
        (gi == 1) ? `OSC_FXT_STABLE_CYC : `OSC_SXT_STABLE_CYC;
      osc_settle_if sif();
      assign sif.run = osc_run[gi];
      assign sif.restart = (gi == 0) ? rc_restart : (gi == 1) ? fxt_restart : sxt_restart;
      assign stable_vec[gi] = sif.stable;
      osc_settle #(.CYCLES(CYC)) u_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif)
      );
    end
  endgenerate

  // frequency delivered follows request only once stable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      internal_rc_freq_sel <= 2'b00;
    else if (stable_vec[0])
      internal_rc_freq_sel <= freq_req;
  end

  // ********************************
  // clock switch delay
  // ********************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      switch_count <= 3'h0;
    else if (do_write && w_strb[0] && osc_decode(aw_addr) == 2'h0 &&
      wbyte[`OSC_BIT_FAST_SEL] != fast_source_sel)
      switch_count <= 3'(`OSC_SWITCH_CYC);
    else if (switch_count != 3'h0)
      switch_count <= switch_count - 3'h1;
  end
  assign clock_switch_busy = (switch_count != 3'h0); // port only; no register reads it back, sys read bit 2 is tied to 0

  // ********************************
  // axi read channel
  // ********************************
  assign sys_rd = {4'h0, fast_source_sel, 1'b0, halt_high_osc_keep, halt_low_osc_keep};
  assign rc_rd = {4'h0, freq_req, stable_vec[0], internal_rc_enable};
  assign fxt_rd = {5'h00, crystal_drive_mode, stable_vec[1], fast_crystal_enable};
  assign sxt_rd = {5'h00, slow_crystal_speedup, stable_vec[2], slow_crystal_enable};
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (osc_decode(s_axi_araddr) == 2'h0)
        s_axi_rdata <= {24'h000000, sys_rd};
      else if (osc_decode(s_axi_araddr) == 2'h1)
        s_axi_rdata <= {24'h000000, rc_rd};
      else if (osc_decode(s_axi_araddr) == 2'h2)
        s_axi_rdata <= {24'h000000, fxt_rd};
      else
        s_axi_rdata <= {24'h000000, sxt_rd};
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ********************************
  // checks
  // ********************************
  sequence s_rc_enable_write;
    rc_restart;
  endsequence

  a_rc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rc_enable_write |=> !stable_vec[0])
    else $error("rc stable not cleared");
  a_fxt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    fxt_restart |=> !stable_vec[1])
    else $error("crystal stable not cleared");
  a_sxt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    sxt_restart |=> !stable_vec[2])
    else $error("slow crystal stable not cleared");
  a_freq_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !stable_vec[0] |=> $stable(internal_rc_freq_sel))
    else $error("frequency changed before stable");
  a_high_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_halted && !halt_high_osc_keep |-> !internal_fast_rc_osc && !fast_crystal_osc)
    else $error("fast oscillator ran during halt");
  a_low_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_halted && !halt_low_osc_keep |-> !slow_crystal_osc)
    else $error("slow oscillator ran during halt");
  a_switch_done: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(clock_switch_busy) |-> ##[1:6] !clock_switch_busy)
    else $error("clock switch too long");
  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0000000)
    else $error("upper bits not zero");
  a_drive_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    crystal_pins_enabled && fast_crystal_enable |=> $stable(crystal_drive_mode))
    else $error("drive mode changed while locked");
endmodule // osc_ctrl

/* File: osc_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite register words
// Notes: included by bare name
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH
`define OSC_ADDR_SYS 4'h0
`define OSC_ADDR_RC 4'h4
`define OSC_ADDR_FXT 4'h8
`define OSC_ADDR_SXT 4'hc
`define OSC_SYS_RESET 8'h00
`define OSC_RC_RESET 8'h01
`define OSC_FXT_RESET 8'h00
`define OSC_SXT_RESET 8'h04
`define OSC_BIT_EN 0
`define OSC_BIT_STABLE 1
`define OSC_BIT_MODE 2
`define OSC_BIT_FAST_SEL 3
`define OSC_BIT_KEEP_HIGH 1
`define OSC_BIT_KEEP_LOW 0
`define OSC_RC_STABLE_NS 1000
`define OSC_FXT_STABLE_NS 4000
`define OSC_SXT_STABLE_NS 32000
`define OSC_CLK_NS 8
`define OSC_RC_STABLE_CYC ((`OSC_RC_STABLE_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_FXT_STABLE_CYC ((`OSC_FXT_STABLE_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_SXT_STABLE_CYC ((`OSC_SXT_STABLE_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_SWITCH_BASE_CYC 4
`define OSC_SWITCH_EXTRA_CYC 2
`define OSC_SWITCH_CYC (`OSC_SWITCH_BASE_CYC + `OSC_SWITCH_EXTRA_CYC)
`endif

/* File: osc_pkg.sv */
// Purpose: shared types
// Assumes: nothing
// Notes: halt-time power modes
package osc_pkg;
  typedef enum logic [1:0] {
    OSC_SLEEP = 2'b00,
    OSC_IDLE0 = 2'b01,
    OSC_IDLE2 = 2'b10,
    OSC_IDLE1 = 2'b11
  } osc_halt_mode_t;
  typedef enum logic [0:0] {
    OSC_ST_WAIT = 1'b0,
    OSC_ST_STABLE = 1'b1
  } osc_settle_state_t;
endpackage

/* File: osc_settle.sv */
// Purpose: settle timer for one oscillator
// Assumes: count fits 16 bits
// Notes: stable falls on restart or when the oscillator stops
`timescale 1ns/10ps
module osc_settle
  import osc_pkg::*;
#(
  parameter int unsigned CYCLES = 16
)
(
  input wire logic aclk,
  input wire logic aresetn,
  osc_settle_if.timer sif
);
  osc_settle_state_t state;
  logic [15:0] count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || sif.restart || !sif.run)
    begin
      state <= OSC_ST_WAIT;
      count <= 16'h0000;
    end
    else
    begin
      case (state)
        OSC_ST_WAIT:
        begin
          count <= count + 16'h0001;
          if (count == 16'(CYCLES - 1))
            state <= OSC_ST_STABLE;
        end
        default: state <= OSC_ST_STABLE;
      endcase
    end
  end

  assign sif.stable = (state == OSC_ST_STABLE);

  a_settle_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    sif.restart |=> !sif.stable)
    else $error("stable not cleared by restart");
endmodule // osc_settle

/* File: osc_settle_if.sv */
// Purpose: carrier between the control top and a settle timer
// Assumes: one clock
// Notes: restart is a one-cycle pulse
`timescale 1ns/10ps
interface osc_settle_if;
  logic run;
  logic restart;
  logic stable;
  modport ctrl (output run, output restart, input stable);
  modport timer (input run, input restart, output stable);
endinterface

/* File: tb.sv */
// Purpose: self-checking bench for osc_ctrl over AXI4-Lite
// Assumes: 125 MHz clock, settle counts as set in osc_defines.svh
// Notes: bench drives every port itself, no partner model
`timescale 1ns/10ps
`include "osc_defines.svh"
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, internal_rc_freq_sel, halt_mode;
  logic cpu_halted, crystal_pins_enabled, internal_fast_rc_osc, fast_crystal_osc;
  logic crystal_drive_mode, slow_crystal_osc, slow_crystal_speedup, clock_switch_busy;
  int err_total = 0;
  int comparisons = 0;
  // ****************************************
  // clock and device
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  osc_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_halted,
    .crystal_pins_enabled, .internal_fast_rc_osc, .internal_rc_freq_sel,
    .fast_crystal_osc, .crystal_drive_mode, .slow_crystal_osc, .slow_crystal_speedup,
    .halt_mode, .clock_switch_busy);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 1000);
    s_axi_bready <= 1'b0;
    chk("bvalid bresp", 32'h4, {29'h0, s_axi_bvalid, s_axi_bresp});
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 1000);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rvalid rresp", 32'h4, {29'h0, s_axi_rvalid, s_axi_rresp});
  endtask
  task automatic poll(input logic [3:0] a, input int lim, output logic [31:0] d);
    int k;
    k = 0;
    do
    begin
      rd(a, d);
      k++;
    end while (d[`OSC_BIT_STABLE] !== 1'b1 && k < lim);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] d;
    rd(`OSC_ADDR_SYS, d);
    chk("sys reset", {24'h0, `OSC_SYS_RESET}, d);
    rd(`OSC_ADDR_RC, d);
    chk("rc reset", {24'h0, `OSC_RC_RESET}, d & 32'hfffffffd);
    rd(`OSC_ADDR_FXT, d);
    chk("fxt reset", {24'h0, `OSC_FXT_RESET}, d);
    rd(`OSC_ADDR_SXT, d);
    chk("sxt reset", {24'h0, `OSC_SXT_RESET}, d);
    chk("osc outputs", 32'h9, {28'h0, internal_fast_rc_osc, fast_crystal_osc,
      slow_crystal_osc, slow_crystal_speedup});
    $display("test reset done");
  endtask
  task automatic t_rc();
    logic [31:0] d;
    logic [1:0] m;
    poll(`OSC_ADDR_RC, 500, d);
    chk("rc settled", 32'h3, d);
    for (int i = 1; i < 4; i++)
    begin
      m = i[1:0];
      wr(`OSC_ADDR_RC, {28'h0, m, 2'b01});
      rd(`OSC_ADDR_RC, d);
      chk("rc restart", {28'h0, m, 2'b01}, d);
      chk("rc freq held", 32'(m - 2'd1), 32'(internal_rc_freq_sel));
      poll(`OSC_ADDR_RC, 500, d);
      chk("rc restable", {28'h0, m, 2'b11}, d);
      chk("rc freq applied", 32'(m), 32'(internal_rc_freq_sel));
    end
    // back to the configured 8MHz rate
    wr(`OSC_ADDR_RC, 32'hfffffff3);
    rd(`OSC_ADDR_RC, d);
    chk("rc upper bits", 32'h1, d);
    wr(`OSC_ADDR_RC, 32'h0);
    chk("rc off", 32'h0, 32'(internal_fast_rc_osc));
    wr(`OSC_ADDR_RC, 32'h1);
    rd(`OSC_ADDR_RC, d);
    chk("rc enable rise", 32'h1, d);
    poll(`OSC_ADDR_RC, 500, d);
    chk("rc on", 32'h3, d);
    $display("test rc done");
  endtask
  task automatic t_fxt();
    logic [31:0] d;
    wr(`OSC_ADDR_FXT, 32'h4);
    chk("drive mode set", 32'h1, 32'(crystal_drive_mode));
    wr(`OSC_ADDR_FXT, 32'h5);
    rd(`OSC_ADDR_FXT, d);
    chk("fxt enable", 32'h5, d);
    chk("fxt running", 32'h1, 32'(fast_crystal_osc));
    poll(`OSC_ADDR_FXT, 1000, d);
    chk("fxt stable", 32'h7, d);
    @(posedge aclk);
    crystal_pins_enabled <= 1'b1;
    wr(`OSC_ADDR_FXT, 32'h1);
    rd(`OSC_ADDR_FXT, d);
    chk("mode locked", 32'h7, d);
    crystal_pins_enabled <= 1'b0;
    wr(`OSC_ADDR_FXT, 32'h1);
    rd(`OSC_ADDR_FXT, d);
    chk("mode free", 32'h3, d);
    chk("drive mode low", 32'h0, 32'(crystal_drive_mode));
    wr(`OSC_ADDR_FXT, 32'h0);
    chk("fxt stopped", 32'h0, 32'(fast_crystal_osc));
    $display("test fxt done");
  endtask
  task automatic t_sxt();
    logic [31:0] d;
    wr(`OSC_ADDR_SXT, 32'h1);
    rd(`OSC_ADDR_SXT, d);
    chk("sxt enable", 32'h5, d);
    chk("sxt running", 32'h1, 32'(slow_crystal_osc));
    poll(`OSC_ADDR_SXT, 3000, d);
    chk("sxt stable", 32'h7, d);
    wr(`OSC_ADDR_SXT, 32'h1);
    rd(`OSC_ADDR_SXT, d);
    chk("sxt ro bits", 32'h7, d);
    // low byte strobe off: nothing lands
    wr(`OSC_ADDR_SXT, 32'h0, 4'he);
    rd(`OSC_ADDR_SXT, d);
    chk("sxt strobe off", 32'h7, d);
    chk("speedup pin", 32'h1, 32'(slow_crystal_speedup));
    $display("test sxt done");
  endtask
  task automatic t_halt();
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      wr(`OSC_ADDR_SYS, 32'(m));
      chk("halt mode", 32'(m), 32'(halt_mode));
      @(posedge aclk);
      cpu_halted <= 1'b1;
      @(posedge aclk);
      @(posedge aclk);
      chk("fast osc halted", 32'(m[1]), 32'(internal_fast_rc_osc));
      chk("slow osc halted", 32'(m[0]), 32'(slow_crystal_osc));
      cpu_halted <= 1'b0;
    end
    $display("test halt done");
  endtask
  task automatic t_switch();
    int n;
    for (int i = 0; i < 2; i++)
    begin
      wr(`OSC_ADDR_SYS, (i == 0) ? 32'h8 : 32'h0);
      chk("switch busy", 32'h1, 32'(clock_switch_busy));
      n = 0;
      while (clock_switch_busy !== 1'b0 && n < 8)
      begin
        @(posedge aclk);
        n++;
      end
      chk("switch bounded", 32'h1, 32'(n < 7));
    end
    $display("test switch done");
  endtask
  // ****************************************
  // sequence, watchdog and verdict
  // ****************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wdata = 32'h0;
    cpu_halted = 1'b0;
    crystal_pins_enabled = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rc();
    t_fxt();
    t_sxt();
    t_halt();
    t_switch();
    close_out();
  end
  initial
  begin
    #(8 * 60000);
    err_total++;
    $display("watchdog expired");
    close_out();
  end
endmodule // tb
